// ==== rtl/sacs_pkg.sv ====
// shared constants and types for the converter sequencer
package sacs_pkg;

  // ----------------------------------------------------------------
  // converter geometry and timing
  // ----------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_MAX_HZ = 16_000_000;
  localparam int CONV_RATIO = 16;
  localparam int SAMPLE_TICKS = 3;
  // divider value d (floored at DIV_MIN) gives a converter tick every d+1 clocks
  localparam int DIV_MIN = (CLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ - 1;
  localparam int PWRUP_NS = 10_000;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 8;
  localparam int WAIT_W = 10;
  localparam int TICK_W = 4;
  localparam int STS_W = 2;
  localparam int SYNC_W = 3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIV = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_START_BIT = 2;
  localparam int STS_DONE_BIT = 0;
  localparam int STS_OVR_BIT = 1;
  localparam int ST_READY_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_EOC_BIT = 2;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h07;

  typedef enum logic [1:0] {
    SACS_IDLE = 2'b00,
    SACS_SAMPLE = 2'b01,
    SACS_BITS = 2'b10,
    SACS_FINISH = 2'b11
  } sacs_core_st_t;

endpackage

// ==== rtl/sacs_sar_core.sv ====
// binary search engine of the successive approximation converter
`timescale 1ns/10ps
module sacs_sar_core
  import sacs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_go,
  input wire logic i_step,
  input wire logic i_cmp_hi,
  output logic o_busy,
  output logic o_sample,
  output logic o_done,
  output logic [RES_W-1:0] o_result,
  output logic [RES_W-1:0] o_dac
);

  typedef struct packed {
    sacs_core_st_t st;
    logic [TICK_W-1:0] tick;
    logic [TICK_W-1:0] bitn;
    logic [RES_W-1:0] dac;
    logic [RES_W-1:0] result;
    logic done;
    logic busy;
    logic sample;
  } sacs_core_t;

  localparam logic [TICK_W-1:0] SAMPLE_LAST = TICK_W'(SAMPLE_TICKS - 1);
  localparam logic [TICK_W-1:0] MSB_IDX = TICK_W'(RES_W - 1);
  localparam logic [RES_W-1:0] MSB_TRIAL = {1'b1, {(RES_W-1){1'b0}}};

  sacs_core_t q;
  sacs_core_t d;
  logic [RES_W-1:0] trial;

  // ----------------------------------------------------------------
  // step engine
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    trial = q.dac;
    d.done = 1'b0;
    case (q.st)
      SACS_IDLE: begin
        if (i_go) begin
          d.st = SACS_SAMPLE;
          d.tick = '0;
          d.dac = '0;
        end
      end
      SACS_SAMPLE: begin
        if (i_step) begin
          if (q.tick == SAMPLE_LAST) begin
            d.st = SACS_BITS;
            d.bitn = MSB_IDX;
            d.dac = MSB_TRIAL;
          end else begin
            d.tick = q.tick + 1'b1;
          end
        end
      end
      SACS_BITS: begin
        if (i_step) begin
          // keep the trial bit only while the input is at or above it
          if (!i_cmp_hi) begin
            trial[q.bitn] = 1'b0;
          end
          if (q.bitn == '0) begin
            d.st = SACS_FINISH;
          end else begin
            d.bitn = q.bitn - 1'b1;
            trial[q.bitn - 1'b1] = 1'b1;
          end
          d.dac = trial;
        end
      end
      SACS_FINISH: begin
        if (i_step) begin
          d.result = q.dac;
          d.done = 1'b1;
          d.st = SACS_IDLE;
        end
      end
      default: begin
        d.st = SACS_IDLE;
      end
    endcase
    d.busy = (d.st != SACS_IDLE);
    d.sample = (d.st == SACS_SAMPLE);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_busy = q.busy;
  assign o_sample = q.sample;
  assign o_done = q.done;
  assign o_result = q.result;
  assign o_dac = q.dac;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_MSB_FIRST: assert property ($rose(q.st == SACS_BITS) |-> q.dac == MSB_TRIAL && q.bitn == MSB_IDX)
    else $error("search did not open on the top bit");
  AST_BIT_DOWN: assert property (q.st == SACS_BITS && i_step && q.bitn != '0 |=> q.bitn == $past(q.bitn) - 1'b1)
    else $error("search skipped a bit");
  AST_DONE_ONCE: assert property (o_done |=> !o_done && q.st != SACS_FINISH)
    else $error("done pulse longer than one cycle");

endmodule // sacs_sar_core

// ==== rtl/sacs_sequencer.sv ====
// conversion sequencer: start control, pacing, power-up wait, result hand-off
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps

module sacs_sequencer
  import sacs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sof,
  input wire logic i_cmp_hi,
  input wire logic i_wake,
  input wire logic i_dma_rd,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_irq,
  output logic o_eoc,
  output logic [RES_W-1:0] o_result,
  output logic [RES_W-1:0] o_dac,
  output logic o_sample,
  output logic o_ready,
  output logic o_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic single;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] cnt;
    logic step;
    logic [WAIT_W-1:0] wcnt;
    logic ready;
    logic pend;
    logic go;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] mask;
    logic irq;
    logic eoc;
    logic [RES_W-1:0] res;
    logic [DATA_W-1:0] rdata;
    logic [SYNC_W-1:0] sof_s;
    logic sof_lvl;
    logic [SYNC_W-1:0] cmp_s;
    logic cmp_lvl;
  } sacs_seq_t;

  localparam logic [DIV_W-1:0] DIV_FLOOR = DIV_W'(DIV_MIN);
  localparam logic [WAIT_W-1:0] PWRUP_LAST = WAIT_W'(PWRUP_CYC - 1);
  localparam int SYNC_A = 1;
  localparam int SYNC_B = 2;

  sacs_seq_t q;
  sacs_seq_t d;
  logic core_busy;
  logic core_done;
  logic [RES_W-1:0] core_result;
  logic sof_evt;
  logic rd_res;
  logic can_go;
  logic [DIV_W-1:0] eff_div;

  function automatic logic sacs_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    sacs_hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.step = 1'b0;
    d.go = 1'b0;
    sof_evt = 1'b0;
    rd_res = 1'b0;
    can_go = 1'b0;

    // converter tick; the floor keeps the tick at or below the
    // converter's top rate whatever software programs
    eff_div = (q.div < DIV_FLOOR) ? DIV_FLOOR : q.div;
    if (q.cnt >= eff_div) begin
      d.cnt = '0;
      d.step = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end

    // pin synchronisers: a change is taken once the last two stages agree
    d.sof_s = {q.sof_s[SYNC_B-1:0], i_sof};
    d.cmp_s = {q.cmp_s[SYNC_B-1:0], i_cmp_hi};
    if (q.sof_s[SYNC_A] == q.sof_s[SYNC_B]) begin
      d.sof_lvl = q.sof_s[SYNC_B];
    end
    if (q.cmp_s[SYNC_A] == q.cmp_s[SYNC_B]) begin
      d.cmp_lvl = q.cmp_s[SYNC_B];
    end
    // an idle frame-start input simply never raises an event
    sof_evt = q.sof_s[SYNC_A] && q.sof_s[SYNC_B] && !q.sof_lvl;

    // power-up wait, restarted by enable and by wake
    if (!q.en || i_wake) begin
      d.wcnt = '0;
      d.ready = 1'b0;
    end else if (!q.ready) begin
      if (q.wcnt == PWRUP_LAST) begin
        d.ready = 1'b1;
      end else begin
        d.wcnt = q.wcnt + 1'b1;
      end
    end

    // launch: continuous runs on, single waits for a pending start
    can_go = q.en && q.ready && !core_busy && !q.go;
    if (can_go && (!q.single || q.pend)) begin
      d.go = 1'b1;
      d.pend = 1'b0;
    end

    // register writes
    if (i_wr) begin
      if (sacs_hit(i_addr, OFF_CTRL)) begin
        d.en = i_wdata[CTRL_EN_BIT];
        d.single = i_wdata[CTRL_SINGLE_BIT];
        if (i_wdata[CTRL_START_BIT]) begin
          d.pend = 1'b1;
        end
      end
      if (sacs_hit(i_addr, OFF_DIV)) begin
        d.div = i_wdata[DIV_W-1:0];
      end
      if (sacs_hit(i_addr, OFF_MASK)) begin
        d.mask = i_wdata[STS_W-1:0];
      end
      if (sacs_hit(i_addr, OFF_STS)) begin
        d.sts = q.sts & ~i_wdata[STS_W-1:0];
      end
    end

    // frame start counts only in single mode, one conversion each
    if (sof_evt && q.single) begin
      d.pend = 1'b1;
    end
    if (!d.en) begin
      d.pend = 1'b0;
    end

    // result hand-off; a new result in the same cycle wins over the read
    rd_res = (i_rd && sacs_hit(i_addr, OFF_RESULT)) || i_dma_rd;
    if (rd_res) begin
      d.eoc = 1'b0;
    end
    if (core_done) begin
      d.eoc = 1'b1;
      d.res = core_result;
      d.sts[STS_DONE_BIT] = 1'b1;
      if (q.eoc && !rd_res) begin
        // previous result was never taken: flag the loss
        d.sts[STS_OVR_BIT] = 1'b1;
      end
    end

    // interrupt follows the status and mask as they will stand
    d.irq = |(d.sts & d.mask);

    // read data, valid the cycle after the strobe only
    d.rdata = '0;
    if (i_rd) begin
      if (sacs_hit(i_addr, OFF_CTRL)) begin
        d.rdata[CTRL_EN_BIT] = q.en;
        d.rdata[CTRL_SINGLE_BIT] = q.single;
        d.rdata[CTRL_START_BIT] = q.pend;
      end
      if (sacs_hit(i_addr, OFF_DIV)) begin
        d.rdata = DATA_W'(q.div);
      end
      if (sacs_hit(i_addr, OFF_STS)) begin
        d.rdata = DATA_W'(q.sts);
      end
      if (sacs_hit(i_addr, OFF_MASK)) begin
        d.rdata = DATA_W'(q.mask);
      end
      if (sacs_hit(i_addr, OFF_RESULT)) begin
        d.rdata = DATA_W'(q.res);
      end
      if (sacs_hit(i_addr, OFF_STATE)) begin
        d.rdata[ST_READY_BIT] = q.ready;
        d.rdata[ST_BUSY_BIT] = core_busy;
        d.rdata[ST_EOC_BIT] = q.eoc;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
      q.div <= DIV_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // search engine
  // ----------------------------------------------------------------
  sacs_sar_core u_core (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_go(q.go),
    .i_step(q.step),
    .i_cmp_hi(q.cmp_lvl),
    .o_busy(core_busy),
    .o_sample(o_sample),
    .o_done(core_done),
    .o_result(core_result),
    .o_dac(o_dac)
  );

  assign o_rdata = q.rdata;
  assign o_irq = q.irq;
  assign o_eoc = q.eoc;
  assign o_result = q.res;
  assign o_ready = q.ready;
  assign o_busy = core_busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_DONE_RAISES: assert property (core_done |=> o_eoc && q.sts[STS_DONE_BIT])
    else $error("finished conversion did not raise done");
  AST_EOC_HOLDS: assert property (o_eoc && !i_dma_rd && !(i_rd && i_addr == OFF_RESULT) |=> o_eoc)
    else $error("done output dropped without a read");
  AST_EOC_CLEARS: assert property (o_eoc && i_dma_rd && !core_done |=> !o_eoc)
    else $error("DMA read did not clear done");
  AST_IRQ_MATCH: assert property (o_irq == |(q.sts & q.mask))
    else $error("interrupt does not follow status and mask");
  AST_NO_EARLY_GO: assert property (q.go |-> $past(q.ready))
    else $error("conversion started before power-up wait");
  AST_WAIT_LEN: assert property ($rose(o_ready) |-> $past(q.wcnt) == PWRUP_LAST)
    else $error("power-up wait of wrong length");
  AST_STEP_RATE: assert property (q.step |=> !q.step [*6])
    else $error("converter tick faster than allowed");
  AST_RESTART: assert property (core_done && q.en && !q.single && q.ready && !i_wr && !i_wake |-> ##[1:2] q.go)
    else $error("continuous mode did not restart");
  AST_SINGLE_GO: assert property (q.go && $past(q.single) |-> $past(q.pend))
    else $error("single mode converted without a start");
  // a start request must survive a launch in the same cycle
  AST_START_PEND: assert property (i_wr && i_addr == OFF_CTRL && i_wdata[CTRL_START_BIT] && i_wdata[CTRL_EN_BIT] |=> q.pend)
    else $error("software start was not held");
  AST_SOF_PEND: assert property (sof_evt && q.single && q.en && !i_wr |=> q.pend)
    else $error("frame start was not held");
  AST_WAKE_DROPS: assert property (i_wake |=> !o_ready)
    else $error("wake did not restart the power-up wait");
  AST_RESULT_LOAD: assert property (core_done |=> o_result == $past(core_result))
    else $error("result not captured on completion");
  // the interrupt must come with the request, not a cycle behind it
  AST_IRQ_ON_EOC: assert property ($rose(o_eoc) && q.mask[STS_DONE_BIT] |-> o_irq)
    else $error("unmasked completion raised no interrupt");
  AST_OVR_SET: assert property (core_done && o_eoc && !i_dma_rd && !i_rd |=> q.sts[STS_OVR_BIT])
    else $error("lost result not flagged");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data outside the read cycle");

  COV_SINGLE: cover property (q.single && q.go ##[1:300] core_done);
  COV_BACK2BACK: cover property (core_done && !q.single ##[1:300] core_done);
  COV_OVERRUN: cover property ($rose(q.sts[STS_OVR_BIT]));
  COV_IRQ: cover property ($rose(o_irq));
  COV_SOF: cover property (sof_evt && q.single);

endmodule // sacs_sequencer

// ==== testbench/sacs_cmp_model.sv ====
// comparator stand-in for the converter's analog front end
`timescale 1ns/10ps
module sacs_cmp_model
  import sacs_pkg::*;
(
  input wire logic [RES_W-1:0] i_dac,
  input wire logic [RES_W-1:0] i_vin,
  output logic o_cmp_hi
);
  // no settling delay: the level follows every new trial word at once
  assign o_cmp_hi = (i_vin >= i_dac);
endmodule // sacs_cmp_model

// ==== testbench/sar_adc_conversion_sequencer_test.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module sar_adc_conversion_sequencer_test;
  import sacs_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 32'h0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_sof = 1'b0, i_wake = 1'b0, i_dma_rd = 1'b0;
  logic cmp_hi, irq, eoc, sample, ready, busy;
  logic [RES_W-1:0] vin = 12'h000;
  logic [RES_W-1:0] result, dac;
  logic [DATA_W-1:0] rdata, d;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int k;

  always #5 i_clk = ~i_clk;

  sacs_sequencer dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_sof(i_sof), .i_cmp_hi(cmp_hi), .i_wake(i_wake),
    .i_dma_rd(i_dma_rd), .o_rdata(rdata), .o_irq(irq), .o_eoc(eoc), .o_result(result),
    .o_dac(dac), .o_sample(sample), .o_ready(ready), .o_busy(busy));
  sacs_cmp_model cmp_u (.i_dac(dac), .i_vin(vin), .o_cmp_hi(cmp_hi));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic sel(input int s);
    return s == 0 ? ready : (s == 1 ? eoc : busy);
  endfunction

  // bounded wait on ready (0), eoc (1) or busy (2)
  // looks only off the edge, once the design's registers have settled
  task automatic wt(input int s, input int n);
    #1;
    for (k = 0; k < n && sel(s) !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    #1 chk("ready", 1'b0, ready);
    chk("eoc", 1'b0, eoc);
    rd(OFF_DIV);
    chk("div", 32'h7, d);
    rd(8'h40);
    chk("unmapped", 32'h0, d);
  endtask

  // start requested before the wait ends must be held, not lost
  task automatic t_powerup();
    vin <= 12'hA5C;
    wr(OFF_MASK, 32'h1);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_CTRL, 32'h7);
    repeat (900) @(posedge i_clk);
    #1 chk("early ready", 1'b0, ready);
    chk("early busy", 1'b0, busy);
    rd(OFF_CTRL);
    chk("start held", 32'h7, d);
    rd(OFF_STATE);
    chk("state early", 32'h0, d);
    wt(0, 200);
    chk("ready", 1'b1, ready);
    wt(1, 300);
    chk("eoc", 1'b1, eoc);
    chk("irq", 1'b1, irq);
    repeat (40) @(posedge i_clk);
    #1 chk("eoc held", 1'b1, eoc);
    chk("dac", 12'hA5C, dac);
    rd(OFF_STATE);
    chk("state done", 32'h5, d);
    rd(OFF_MASK);
    chk("mask", 32'h1, d);
    rd(OFF_STS);
    chk("sts done", 32'h1, d & 32'h1);
    rd(OFF_RESULT);
    chk("result", {20'h0, 12'hA5C}, d);
    #1 chk("eoc cleared", 1'b0, eoc);
    wr(OFF_STS, 32'h3);
    #1 chk("irq cleared", 1'b0, irq);
  endtask

  // frame starts driven by another logic block, one conversion each
  task automatic t_sof();
    logic [RES_W-1:0] vals [2] = '{12'hFFF, 12'h000};
    foreach (vals[i]) begin
      vin <= vals[i];
      @(posedge i_clk);
      i_sof <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_sof <= 1'b0;
      wt(1, 300);
      chk("sof eoc", 1'b1, eoc);
      rd(OFF_RESULT);
      chk("sof result", {20'h0, vals[i]}, d);
    end
    repeat (300) @(posedge i_clk);
    #1 chk("one per frame", 1'b0, eoc | busy);
  endtask

  // continuous: results drained by dma strobes, the last one by a register read after the overrun
  task automatic t_cont();
    vin <= 12'h3C7;
    wr(OFF_DIV, 32'h2);
    rd(OFF_DIV);
    chk("div raw", 32'h2, d);
    wr(OFF_CTRL, 32'h1);
    repeat (3) begin
      wt(1, 300);
      chk("cont eoc", 1'b1, eoc);
      chk("cont result", 12'h3C7, result);
      @(posedge i_clk);
      i_dma_rd <= 1'b1;
      @(posedge i_clk);
      i_dma_rd <= 1'b0;
      #1 chk("dma clear", 1'b0, eoc);
      wt(2, 4);
      chk("restart", 1'b1, busy);
      chk("sampling", 1'b1, sample);
    end
    rd(OFF_STS);
    chk("no overrun", 32'h1, d);
    wt(1, 300);
    repeat (300) @(posedge i_clk);
    rd(OFF_STS);
    chk("overrun", 32'h3, d);
    wr(OFF_CTRL, 32'h0);
    repeat (200) @(posedge i_clk);
    rd(OFF_RESULT);
    wr(OFF_STS, 32'h3);
  endtask

  // wake restarts the power-up wait
  task automatic t_wake();
    vin <= 12'h5A1;
    wr(OFF_CTRL, 32'h3);
    repeat (1100) @(posedge i_clk);
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 chk("wake ready", 1'b0, ready);
    wr(OFF_CTRL, 32'h7);
    repeat (800) @(posedge i_clk);
    #1 chk("wake busy", 1'b0, busy);
    wt(0, 300);
    chk("wake ready up", 1'b1, ready);
    wt(1, 300);
    chk("wake eoc", 1'b1, eoc);
    rd(OFF_RESULT);
    chk("wake result", {20'h0, 12'h5A1}, d);
  endtask

  // ----------------------------------------------------------------
  // sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_powerup();
    t_sof();
    t_cont();
    t_wake();
    stop_test();
  end
endmodule // sar_adc_conversion_sequencer_test
